// [smcp_pkg.sv]
// Constants, register map and state codes of the smart card character link.
// Assumes a 20 MHz system clock; nothing else is assumed of the surroundings.
package smcp_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 20000000;
	localparam int unsigned ETU_NS     = 93000;
	localparam int unsigned ETU_CYC    = ETU_NS / (1000000000 / SYS_CLK_HZ);
	localparam int unsigned T0_GUARDS  = 2;
	localparam int unsigned T1_GUARDS  = 1;
	localparam int unsigned RXQ_DEPTH  = 16;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] ADR_LINE_CTRL = 5'h00;
	localparam logic [4:0] ADR_ERR_CTRL  = 5'h04;
	localparam logic [4:0] ADR_INT_EN    = 5'h08;
	localparam logic [4:0] ADR_LINE_STAT = 5'h0C;
	localparam logic [4:0] ADR_RX_BUF    = 5'h10;
	localparam logic [4:0] ADR_TX_QUEUE  = 5'h14;
	localparam logic [4:0] ADR_FIFO_STAT = 5'h18;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned LC_TX_SEL  = 0;
	localparam int unsigned LC_RX_SEL  = 1;
	localparam int unsigned LC_ORDER   = 2;
	localparam int unsigned LC_INVERSE = 3;
	localparam int unsigned LC_EPS     = 4;
	localparam int unsigned LC_RX_DMA  = 5;
	localparam int unsigned LC_TX_DMA  = 6;
	localparam int unsigned EC_RT_LSB  = 0;
	localparam int unsigned EC_PT_LSB  = 3;
	localparam int unsigned EC_SKIP    = 6;
	localparam int unsigned EC_REPEAT  = 7;
	localparam int unsigned LS_RETX    = 0;
	localparam int unsigned LS_PARITY_ERROR_FLAG    = 1;
	localparam int unsigned LS_OVR     = 2;
	localparam int unsigned LS_FRM     = 3;
	localparam int unsigned RB_PARITY_ERROR_FLAG    = 8;
	localparam int unsigned FS_PCNT    = 5;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [6:0] LINE_CTRL_RST = 7'h00;
	localparam logic [5:0] ERR_CTRL_RST  = 6'h1B;
	localparam logic [3:0] INT_EN_RST    = 4'h0;

	// ---------------------------------------------------------------
	// Character engine states
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_TXB  = 6'h02,
		ST_TXG  = 6'h04,
		ST_RXB  = 6'h08,
		ST_RXG  = 6'h10,
		ST_HALT = 6'h20
	} smcp_state_e;

endpackage : smcp_pkg

// [smcp_rx_queue.sv]
// Receive queue of characters with a per-entry parity flag in the top bit.
// Ignores a push when full and a pop when empty.
`timescale 1ns/100ps
module smcp_rx_queue #(
	parameter int unsigned W     = 9,
	parameter int unsigned DEPTH = smcp_pkg::RXQ_DEPTH,
	parameter int unsigned CW    = $clog2(DEPTH) + 1
) (
	input  wire logic          sys_clk_i,
	input  wire logic          arst_n_i,
	input  wire logic          push_i,
	input  wire logic [W-1:0]  data_i,
	input  wire logic          pop_i,
	output logic      [W-1:0]  data_o,
	output logic      [CW-1:0] count_o,
	output logic      [CW-1:0] parity_error_flag_count_o,
	output logic               full_o,
	output logic               empty_o
);

	localparam int unsigned AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("smcp_rx_queue: DEPTH must be a power of two");
		end
	endgenerate

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] pcnt_r;
	wire           do_push = push_i && !full_o;
	wire           do_pop  = pop_i && !empty_o;
	wire           in_pe   = do_push && data_i[W-1];
	wire           out_pe  = do_pop && mem_r[rp_r][W-1];

	assign data_o       = mem_r[rp_r];
	assign count_o      = cnt_r;
	assign parity_error_flag_count_o = pcnt_r;
	assign full_o       = cnt_r == CW'(DEPTH);
	assign empty_o      = cnt_r == '0;

	always_ff @(posedge sys_clk_i) begin
		if (do_push) begin
			mem_r[wp_r] <= data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_r   <= '0;
			rp_r   <= '0;
			cnt_r  <= '0;
			pcnt_r <= '0;
		end else begin
			wp_r   <= wp_r + AW'(do_push);
			rp_r   <= rp_r + AW'(do_pop);
			cnt_r  <= cnt_r + CW'(do_push) - CW'(do_pop);
			pcnt_r <= pcnt_r + CW'(in_pe) - CW'(out_pe);
		end
	end

endmodule : smcp_rx_queue

// [smcp_char_link.sv]
// Character engine of a smart card single-wire link with its registers.
// Assumes an open-drain I/O line with external pull-up, and a host on a
// plain register port that reads data one cycle after the read strobe.
//
// What this block does
// - Separate protocol select for transmit and receive
// - T0 transmit adds two guard moments
// - T1 adds one guard, never resends
// - Interrupt, polling or DMA request servicing
// - T0 receive flags parity or full queue
// - T0 transmit senses low, resends byte
// - Resend limit halts, sets flag, interrupts
// - Host skips or repeats; engine resumes
// - T1 never raises the resend error
// - T0 parity error signalled, byte dropped
// - Parity flag at trigger; always signal
// - Keep receiving and signalling after interrupt
// - T1 stores bad byte, flags, no signal
// - Count of flagged bytes is readable
// - Sixteen entries; seventeenth dropped, overrun
// - T0 overrun also signalled to card
// - Low in last guard sets framing
// - Start, eight data, parity, guard moments
// - Direct or inverse convention, two bits
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module smcp_char_link #(
	parameter logic [15:0] ETU_CYC = 16'(smcp_pkg::ETU_CYC)
) (
	input  wire logic                        sys_clk_i,
	input  wire logic                        arst_n_i,
	input  wire logic [smcp_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [31:0]                 wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [31:0]                 rdata_o,
	input  wire logic                        io_i,
	output logic                             io_o,
	output logic                             io_oe_o,
	output logic                             irq_o,
	output logic                             rx_dma_req_o,
	output logic                             tx_dma_req_o
);

	generate
		if (ETU_CYC < 16'h0004 || ETU_CYC > 16'h7FFF) begin : g_bad_etu
			$error("smcp_char_link: ETU_CYC out of range");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Line synchroniser
	// ---------------------------------------------------------------
	logic [2:0] sync_r;
	logic       line_r;
	logic       line_prev_r;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_r      <= 3'h7;
			line_r      <= 1'b1;
			line_prev_r <= 1'b1;
		end else begin
			sync_r      <= {sync_r[1:0], io_i};
			line_r      <= (sync_r[2] == sync_r[1]) ? sync_r[1] : line_r;
			line_prev_r <= line_r;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [6:0] lc_r;
	logic [5:0] ec_r;
	logic [3:0] ie_r;
	logic [3:0] ls_r;
	logic [3:0] ls_nxt;
	logic [7:0] tx_data_r;
	logic       tx_full_r;
	logic [31:0] rdata_r;
	logic [8:0] q_head;
	logic [4:0] q_cnt;
	logic [4:0] q_pcnt;
	logic       q_full;
	logic       q_empty;

	wire tx_sel  = lc_r[smcp_pkg::LC_TX_SEL];
	wire rx_sel  = lc_r[smcp_pkg::LC_RX_SEL];
	wire ord_msb = lc_r[smcp_pkg::LC_ORDER];
	wire inv     = lc_r[smcp_pkg::LC_INVERSE];
	wire eps     = lc_r[smcp_pkg::LC_EPS];
	wire [2:0] rt_lvl = ec_r[smcp_pkg::EC_RT_LSB +: 3];
	wire [2:0] pt_lvl = ec_r[smcp_pkg::EC_PT_LSB +: 3];

	wire wr_lc = wr_i && addr_i == smcp_pkg::ADR_LINE_CTRL;
	wire wr_ec = wr_i && addr_i == smcp_pkg::ADR_ERR_CTRL;
	wire wr_ie = wr_i && addr_i == smcp_pkg::ADR_INT_EN;
	wire wr_ls = wr_i && addr_i == smcp_pkg::ADR_LINE_STAT;
	wire wr_tq = wr_i && addr_i == smcp_pkg::ADR_TX_QUEUE;
	wire rd_rb = rd_i && addr_i == smcp_pkg::ADR_RX_BUF;
	wire skip  = wr_ec && wdata_i[smcp_pkg::EC_SKIP];
	wire rept  = wr_ec && wdata_i[smcp_pkg::EC_REPEAT];
	wire [3:0] ls_clr = wr_ls ? wdata_i[3:0] : 4'h0;

	wire [31:0] rd_mux =
		(addr_i == smcp_pkg::ADR_LINE_CTRL) ? {25'h0, lc_r} :
		(addr_i == smcp_pkg::ADR_ERR_CTRL)  ? {26'h0, ec_r} :
		(addr_i == smcp_pkg::ADR_INT_EN)    ? {28'h0, ie_r} :
		(addr_i == smcp_pkg::ADR_LINE_STAT) ?
			{26'h0, tx_full_r, !q_empty, ls_r} :
		(addr_i == smcp_pkg::ADR_RX_BUF)    ? {23'h0, q_head} :
		(addr_i == smcp_pkg::ADR_FIFO_STAT) ? {22'h0, q_pcnt, q_cnt} :
		32'h0;

	assign rdata_o      = rdata_r;
	assign irq_o        = |(ls_r & ie_r);
	assign rx_dma_req_o = lc_r[smcp_pkg::LC_RX_DMA] && !q_empty;
	assign tx_dma_req_o = lc_r[smcp_pkg::LC_TX_DMA] && !tx_full_r;
	assign io_o         = 1'b0;

	// ---------------------------------------------------------------
	// Character engine
	// ---------------------------------------------------------------
	smcp_pkg::smcp_state_e st_r;
	smcp_pkg::smcp_state_e st_nxt;
	logic [15:0] cnt_r;
	logic [3:0]  bit_r;
	logic [9:0]  tx_frm_r;
	logic [8:0]  rx_sh_r;
	logic        nak_r;
	logic        sig_r;
	logic [2:0]  resend_r;
	logic [2:0]  prep_r;

	wire [15:0] half = {1'b0, ETU_CYC[15:1]};
	wire [15:0] etu2 = {ETU_CYC[14:0], 1'b0};
	wire etu_end = cnt_r == ETU_CYC - 16'h0001;
	wire half_pt = cnt_r == half - 16'h0001;
	wire [15:0] tx_glim = (tx_sel ? ETU_CYC : etu2) - 16'h0001;
	wire [15:0] rx_glim = (rx_sel ? ETU_CYC : etu2) - 16'h0001;
	wire st_idle = st_r == smcp_pkg::ST_IDLE;
	wire st_txb  = st_r == smcp_pkg::ST_TXB;
	wire st_txg  = st_r == smcp_pkg::ST_TXG;
	wire st_rxb  = st_r == smcp_pkg::ST_RXB;
	wire st_rxg  = st_r == smcp_pkg::ST_RXG;
	wire st_halt = st_r == smcp_pkg::ST_HALT;

	wire fall   = line_prev_r && !line_r;
	wire go_rx  = st_idle && fall;
	wire go_tx  = st_idle && tx_full_r && !fall;
	wire resume = st_halt && (skip || rept);
	wire tx_be  = st_txb && etu_end;
	wire tx_lst = tx_be && bit_r == 4'h9;
	wire nak_sm = st_txg && !tx_sel && !line_r
		&& cnt_r == ETU_CYC + half - 16'h0001;
	wire tx_ge  = st_txg && cnt_r == tx_glim;
	wire rx_smp = st_rxb && ((bit_r == 4'h0) ? half_pt : etu_end);
	wire rx_abt = rx_smp && bit_r == 4'h0 && line_r;
	wire rx_lst = rx_smp && bit_r == 4'h9;
	wire rx_ge  = st_rxg && cnt_r == rx_glim;
	wire frm_ev = rx_ge && !line_r;
	wire [3:0] rsn_inc = {1'b0, resend_r} + 4'h1;
	wire [3:0] prp_inc = {1'b0, prep_r} + 4'h1;
	wire retx_ev = tx_ge && nak_r && rsn_inc >= {1'b0, rt_lvl};
	wire cnt_clr = go_rx || go_tx || resume || tx_be || tx_ge
		|| rx_smp || rx_ge;

	// Convention decode and encode, one bit position per loop pass.
	wire [8:0] rx_raw = {line_r, rx_sh_r[8:1]};
	wire [7:0] rx_dec;
	wire [7:0] tx_enc;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_conv
			assign rx_dec[gi] = (ord_msb ? rx_raw[7-gi] : rx_raw[gi]) ^ inv;
			assign tx_enc[gi] = (ord_msb ? tx_data_r[7-gi] : tx_data_r[gi])
				^ inv;
		end
	endgenerate
	wire rx_par  = rx_raw[8] ^ inv;
	wire rx_parity_error_flag = (^rx_dec ^ rx_par) == eps;
	wire tx_par  = (^tx_data_r ^ !eps) ^ inv;

	wire sig_set = !rx_sel && (rx_parity_error_flag || q_full);
	wire push    = rx_lst && !q_full && (rx_sel || !rx_parity_error_flag);
	wire ovr_ev  = rx_lst && q_full;
	wire parity_error_flag_ev = rx_lst && rx_parity_error_flag
		&& (rx_sel || prp_inc >= {1'b0, pt_lvl});
	wire sig_oe  = st_rxg && sig_r && cnt_r >= half
		&& cnt_r < half + ETU_CYC;
	wire pop     = rd_rb && !q_empty;

	assign io_oe_o = (st_txb && !tx_frm_r[bit_r]) || sig_oe;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			smcp_pkg::ST_IDLE: begin
				if (go_rx) begin
					st_nxt = smcp_pkg::ST_RXB;
				end else if (go_tx) begin
					st_nxt = smcp_pkg::ST_TXB;
				end
			end
			smcp_pkg::ST_TXB: begin
				if (tx_lst) begin
					st_nxt = smcp_pkg::ST_TXG;
				end
			end
			smcp_pkg::ST_TXG: begin
				if (tx_ge) begin
					st_nxt = !nak_r ? smcp_pkg::ST_IDLE :
						retx_ev ? smcp_pkg::ST_HALT : smcp_pkg::ST_TXB;
				end
			end
			smcp_pkg::ST_RXB: begin
				if (rx_abt) begin
					st_nxt = smcp_pkg::ST_IDLE;
				end else if (rx_lst) begin
					st_nxt = smcp_pkg::ST_RXG;
				end
			end
			smcp_pkg::ST_RXG: begin
				if (rx_ge) begin
					st_nxt = smcp_pkg::ST_IDLE;
				end
			end
			smcp_pkg::ST_HALT: begin
				if (skip) begin
					st_nxt = smcp_pkg::ST_IDLE;
				end else if (rept) begin
					st_nxt = smcp_pkg::ST_TXB;
				end
			end
			default: st_nxt = smcp_pkg::ST_IDLE;
		endcase
	end

	// Hardware set wins over a software clear in the same cycle.
	assign ls_nxt = (ls_r & ~ls_clr)
		| {frm_ev, ovr_ev, parity_error_flag_ev, retx_ev};

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lc_r    <= smcp_pkg::LINE_CTRL_RST;
			ec_r    <= smcp_pkg::ERR_CTRL_RST;
			ie_r    <= smcp_pkg::INT_EN_RST;
			ls_r    <= 4'h0;
			rdata_r <= 32'h0;
		end else begin
			lc_r    <= wr_lc ? wdata_i[6:0] : lc_r;
			ec_r    <= wr_ec ? wdata_i[5:0] : ec_r;
			ie_r    <= wr_ie ? wdata_i[3:0] : ie_r;
			ls_r    <= ls_nxt;
			rdata_r <= rd_i ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_data_r <= 8'h00;
			tx_full_r <= 1'b0;
		end else begin
			tx_data_r <= (wr_tq && !tx_full_r) ? wdata_i[7:0] : tx_data_r;
			tx_full_r <= (wr_tq && !tx_full_r)
				|| (tx_full_r && !(tx_ge && !nak_r) && !(st_halt && skip));
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r     <= smcp_pkg::ST_IDLE;
			cnt_r    <= 16'h0000;
			bit_r    <= 4'h0;
			tx_frm_r <= 10'h3FF;
			rx_sh_r  <= 9'h000;
			nak_r    <= 1'b0;
			sig_r    <= 1'b0;
			resend_r <= 3'h0;
			prep_r   <= 3'h0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_clr ? 16'h0000 : cnt_r + 16'h0001;
			bit_r <= (go_rx || go_tx || resume || tx_lst || rx_lst) ? 4'h0 :
				(tx_be || rx_smp) ? bit_r + 4'h1 : bit_r;
			tx_frm_r <= go_tx ? {tx_par, tx_enc, 1'b0} : tx_frm_r;
			rx_sh_r  <= rx_smp ? rx_raw : rx_sh_r;
			nak_r    <= st_txb ? 1'b0 : (nak_r || nak_sm);
			sig_r    <= rx_lst ? sig_set : sig_r;
			if (tx_ge && !nak_r || resume) begin
				resend_r <= 3'h0;
			end else if (tx_ge && nak_r && !retx_ev) begin
				resend_r <= rsn_inc[2:0];
			end
			if (rx_lst && !rx_sel && rx_parity_error_flag) begin
				prep_r <= (prp_inc >= {1'b0, pt_lvl}) ? 3'h0 : prp_inc[2:0];
			end else if (rx_lst && !q_full) begin
				prep_r <= 3'h0;
			end
		end
	end

	smcp_rx_queue #(
		.W     (9),
		.DEPTH (smcp_pkg::RXQ_DEPTH)
	) u_rxq (
		.sys_clk_i    (sys_clk_i),
		.arst_n_i     (arst_n_i),
		.push_i       (push),
		.data_i       ({rx_parity_error_flag, rx_dec}),
		.pop_i        (pop),
		.data_o       (q_head),
		.count_o      (q_cnt),
		.parity_error_flag_count_o (q_pcnt),
		.full_o       (q_full),
		.empty_o      (q_empty)
	);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	logic [15:0] sig_len_r;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sig_len_r <= 16'h0000;
		end else begin
			sig_len_r <= sig_oe ? sig_len_r + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_sig_pulse_len: assert property ($fell(sig_oe) |-> sig_len_r == ETU_CYC)
		else $error("error signal not one etu long");
	a_t1_rx_silent: assert property (sig_oe |-> !sig_r || !$past(rx_sel, 1) || !rx_sel)
		else $error("error signal driven in T1 receive");
	a_t1_no_retx: assert property ($rose(ls_r[0]) |-> $past(st_txg && !tx_sel))
		else $error("resend error outside T0 transmit");
	a_overrun_set: assert property (ovr_ev |=> ls_r[2] && q_cnt <= 5'h10)
		else $error("overrun not flagged");
	a_t0_parity_error_flag_drop: assert property (rx_lst && !rx_sel && rx_parity_error_flag |=> q_cnt <= $past(q_cnt))
		else $error("bad T0 byte entered queue");
	a_halt_quiet: assert property (st_halt |-> !io_oe_o && tx_full_r)
		else $error("line driven while halted");
	a_frame_set: assert property (frm_ev |=> ls_r[3])
		else $error("framing error not flagged");
	a_resend_go: assert property (tx_ge && nak_r && !retx_ev |=> st_txb && bit_r == 4'h0 ##1 io_oe_o)
		else $error("no resend after error signal");

	c_sig_sent:  cover property ($rose(sig_oe));
	c_halted:    cover property ($rose(st_halt));
	c_t1_flag:   cover property (push && rx_parity_error_flag);
	c_frame_err: cover property (frm_ev);

endmodule : smcp_char_link

// [smcp_card_model.sv]
// Behavioural card on the open-drain I/O line of the character link.
// Assumes a pull-up on the line and an etu of two card clock periods.
`timescale 1ns/100ps
module smcp_card_model #(
	parameter int ETU_NS = 800
) (
	input  wire logic clk_i,
	input  wire logic io_i,
	output logic      low_o
);
	// ---------------------------------------------------------------
	// Card transfers
	// ---------------------------------------------------------------
	initial low_o = 1'b0;

	// Sends one character; err_o is the line seen low in the guard time.
	task automatic send(input logic [7:0] d, input logic inv, bad, frm,
		output logic err_o);
		logic [9:0] b;
		b[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			b[i + 1] = inv ? ~d[7 - i] : d[i];
		b[9] = ~^d ^ bad ^ inv;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			low_o <= ~b[i];
			@(posedge clk_i);
		end
		@(posedge clk_i);
		low_o <= frm;
		@(posedge clk_i);
		@(posedge clk_i);
		err_o = ~io_i;
		repeat (5) @(posedge clk_i);
		low_o <= 1'b0;
	endtask : send

	// Takes one character; a nack pulls the line low in the guard time.
	task automatic recv(input logic nack, inv, output logic [7:0] d,
		output logic p, output realtime t);
		logic [9:0] b;
		@(negedge io_i);
		t = $realtime;
		#(ETU_NS / 2);
		for (int i = 0; i < 10; i++) begin
			b[i] = io_i;
			#(ETU_NS);
		end
		for (int i = 0; i < 8; i++)
			d[i] = inv ? ~b[8 - i] : b[i + 1];
		p = b[9] ^ inv;
		if (nack) begin
			low_o = 1'b1;
			#(ETU_NS * 5 / 4);
			low_o = 1'b0;
		end
	endtask : recv
endmodule : smcp_card_model

// [smcp_char_link_tb.sv]
// Self-checking bench of the smart card character link.
// Assumes the card model and the device share one line with a pull-up.
`timescale 1ns/100ps
module smcp_char_link_tb;
	localparam int         ETU    = 16;
	localparam int         ETU_NS = ETU * 50;
	localparam logic [4:0] LC     = smcp_pkg::ADR_LINE_CTRL;
	localparam logic [4:0] EC     = smcp_pkg::ADR_ERR_CTRL;
	localparam logic [4:0] LS     = smcp_pkg::ADR_LINE_STAT;
	localparam logic [4:0] RB     = smcp_pkg::ADR_RX_BUF;
	localparam logic [4:0] TQ     = smcp_pkg::ADR_TX_QUEUE;
	localparam logic [4:0] FS     = smcp_pkg::ADR_FIFO_STAT;
	logic        clk      = 1'b0;
	logic        card_clk = 1'b0;
	logic        arst_n   = 1'b0;
	logic [4:0]  addr     = 5'h00;
	logic [31:0] wdata    = 32'h0;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic [31:0] rdata;
	logic        io_o;
	logic        io_oe;
	logic        irq;
	logic        rxd;
	logic        txd;
	logic        card_low;
	logic        io_w;
	realtime     t_prev;
	realtime     t_last;
	int          fails    = 0;
	int          checks   = 0;

	always #25 clk = ~clk;
	always #200 card_clk = ~card_clk;
	assign io_w = ~((io_oe & ~io_o) | card_low);

	smcp_char_link #(
		.ETU_CYC (16'h0010)
	) i_smcp_char_link (
		.sys_clk_i    (clk),
		.arst_n_i     (arst_n),
		.addr_i       (addr),
		.wdata_i      (wdata),
		.wr_i         (wr),
		.rd_i         (rd),
		.rdata_o      (rdata),
		.io_i         (io_w),
		.io_o         (io_o),
		.io_oe_o      (io_oe),
		.irq_o        (irq),
		.rx_dma_req_o (rxd),
		.tx_dma_req_o (txd)
	);

	smcp_card_model #(
		.ETU_NS (ETU_NS)
	) i_smcp_card_model (
		.clk_i (card_clk),
		.io_i  (io_w),
		.low_o (card_low)
	);

	// ---------------------------------------------------------------
	// Bus and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input string n, input logic [4:0] a,
		input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 chk(n, e, rdata);
	endtask : rd_chk

	task automatic take(input logic [7:0] e, input logic nack, inv);
		logic [7:0] d;
		logic       p;
		t_prev = t_last;
		i_smcp_card_model.recv(nack, inv, d, p, t_last);
		chk("tx data", {24'h0, e}, {24'h0, d});
		chk("tx parity", {31'h0, ~^e}, {31'h0, p});
		if (!nack)
			repeat (2 * ETU) @(posedge clk);
	endtask : take

	task automatic card_tx(input logic [7:0] d, input logic inv, bad, frm,
		e);
		logic s;
		i_smcp_card_model.send(d, inv, bad, frm, s);
		chk("error signal", {31'h0, e}, {31'h0, s});
	endtask : card_tx

	function automatic logic gap_in(input int n);
		return (t_last - t_prev >= n * ETU_NS) &&
			(t_last - t_prev < n * ETU_NS + 500);
	endfunction : gap_in

	task automatic final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		rd_chk("line ctrl", LC, 32'h0);
		rd_chk("err ctrl", EC, 32'h1B);
		rd_chk("unmapped", 5'h1C, 32'h0);
		wr_reg(smcp_pkg::ADR_INT_EN, 32'hF);
		wr_reg(LC, 32'h40);
		#1 chk("tx dma", 32'h1, {31'h0, txd});
		wr_reg(LC, 32'h0);
		$display("done regs");
	endtask : t_regs

	task automatic t_tx_t0;
		wr_reg(EC, 32'h12);
		wr_reg(TQ, 32'hA5);
		take(8'hA5, 1'b1, 1'b0);
		take(8'hA5, 1'b0, 1'b0);
		chk("t0 gap", 32'h1, {31'h0, gap_in(12)});
		wr_reg(TQ, 32'h5A);
		take(8'h5A, 1'b1, 1'b0);
		take(8'h5A, 1'b0, 1'b0);
		rd_chk("no halt", LS, 32'h0);
		wr_reg(TQ, 32'hC3);
		take(8'hC3, 1'b1, 1'b0);
		take(8'hC3, 1'b1, 1'b0);
		repeat (ETU) @(posedge clk);
		rd_chk("halted", LS, 32'h21);
		chk("irq", 32'h1, {31'h0, irq});
		wr_reg(LS, 32'h1);
		wr_reg(EC, 32'h92);
		take(8'hC3, 1'b0, 1'b0);
		wr_reg(TQ, 32'h0F);
		take(8'h0F, 1'b1, 1'b0);
		take(8'h0F, 1'b1, 1'b0);
		repeat (ETU) @(posedge clk);
		wr_reg(EC, 32'h52);
		rd_chk("skipped", LS, 32'h1);
		wr_reg(LS, 32'h1);
		$display("done t0 transmit");
	endtask : t_tx_t0

	// Host side sends a five-byte command header, one byte at a time.
	task automatic t_header;
		for (int i = 0; i < 5; i++) begin
			wr_reg(TQ, 32'hA0 + 32'(i));
			take(8'hA0 + 8'(i), 1'b0, 1'b0);
		end
		rd_chk("header done", LS, 32'h0);
		$display("done header");
	endtask : t_header

	task automatic t_tx_protocol_select;
		wr_reg(LC, 32'h1);
		wr_reg(TQ, 32'h96);
		take(8'h96, 1'b1, 1'b0);
		chk("no resend", 32'h0, {31'h0, io_oe});
		repeat (ETU) @(posedge clk);
		rd_chk("t1 no flag", LS, 32'h0);
		$display("done t1 transmit");
	endtask : t_tx_protocol_select

	task automatic t_rx_t0;
		wr_reg(LC, 32'h0);
		wr_reg(EC, 32'h11);
		card_tx(8'h3B, 1'b0, 1'b1, 1'b0, 1'b1);
		rd_chk("below level", LS, 32'h0);
		card_tx(8'h3B, 1'b0, 1'b0, 1'b0, 1'b0);
		card_tx(8'h3B, 1'b0, 1'b1, 1'b0, 1'b1);
		rd_chk("count cleared", LS, 32'h10);
		card_tx(8'h3B, 1'b0, 1'b1, 1'b0, 1'b1);
		rd_chk("at level", LS, 32'h12);
		rd_chk("bad dropped", FS, 32'h1);
		rd_chk("rx byte", RB, 32'h3B);
		wr_reg(LS, 32'h2);
		$display("done t0 receive");
	endtask : t_rx_t0

	task automatic t_rx_protocol_select;
		wr_reg(LC, 32'h2);
		card_tx(8'h81, 1'b0, 1'b1, 1'b0, 1'b0);
		rd_chk("t1 parity_error_flag", LS, 32'h12);
		chk("irq", 32'h1, {31'h0, irq});
		rd_chk("parity_error_flag count", FS, 32'h21);
		rd_chk("flagged byte", RB, 32'h181);
		rd_chk("count zero", FS, 32'h0);
		wr_reg(LS, 32'h2);
		card_tx(8'h55, 1'b0, 1'b0, 1'b1, 1'b1);
		rd_chk("framing", LS, 32'h18);
		rd_chk("frame byte", RB, 32'h55);
		wr_reg(LS, 32'h8);
		$display("done t1 receive");
	endtask : t_rx_protocol_select

	task automatic t_overrun;
		wr_reg(LC, 32'h20);
		for (int i = 0; i < 16; i++)
			card_tx(8'h40 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b0);
		rd_chk("full", FS, 32'h10);
		chk("rx dma", 32'h1, {31'h0, rxd});
		card_tx(8'hEE, 1'b0, 1'b0, 1'b0, 1'b1);
		rd_chk("overrun", LS, 32'h14);
		for (int i = 0; i < 16; i++)
			rd_chk("drain", RB, 32'h40 + 32'(i));
		chk("rx dma off", 32'h0, {31'h0, rxd});
		wr_reg(LS, 32'h4);
		$display("done overrun");
	endtask : t_overrun

	task automatic t_inverse;
		wr_reg(LC, 32'hC);
		card_tx(8'h3F, 1'b1, 1'b0, 1'b0, 1'b0);
		rd_chk("inverse rx", RB, 32'h3F);
		wr_reg(TQ, 32'hC5);
		take(8'hC5, 1'b0, 1'b1);
		$display("done inverse");
	endtask : t_inverse

	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_tx_t0;
		t_header;
		t_tx_protocol_select;
		t_rx_t0;
		t_rx_protocol_select;
		t_overrun;
		t_inverse;
		final_report;
	end

	initial begin
		#(4000000);
		fails++;
		final_report;
	end
endmodule : smcp_char_link_tb
